// File: lpa_pkg.sv
// Package of constants and types for the LMFC to SYSREF phase alignment block.
package lpa_pkg;
	localparam logic [7:0] ADDR_CHECKS = 8'h30;
	localparam logic [7:0] ADDR_ERR_WINDOW = 8'h34;
	localparam logic [7:0] ADDR_PREV_ERR_LOW = 8'h38;
	localparam logic [7:0] ADDR_PREV_ERR_HIGH = 8'h39;
	localparam logic [7:0] ADDR_CONTROL = 8'h3A;
	localparam logic [7:0] ADDR_STATUS = 8'h3B;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int CTL_ON_BIT = 7;
	localparam int CTL_ARM_BIT = 6;
	localparam int CTL_CLR_STICKY_BIT = 5;
	localparam int CTL_CLR_PREV_BIT = 4;
	localparam int PREV_LOW_BIT = 7;
	localparam int PREV_HIGH_BIT = 6;
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_LOCK_BIT = 3;
	localparam int STAT_ROTATE_BIT = 2;
	localparam int STAT_LIMIT_BIT = 1;
	localparam int STAT_TRIP_BIT = 0;
	localparam int CHK_SUBCLASS_BIT = 1;
	localparam int CHK_INTERP_BIT = 0;
	localparam logic [2:0] MAX_SUBCLASS = 3'h1;
	localparam logic [3:0] INTERP_X1 = 4'h1;
	localparam logic [3:0] INTERP_X2 = 4'h2;
	localparam logic [3:0] INTERP_X4 = 4'h4;
	localparam logic [3:0] INTERP_X8 = 4'h8;
	typedef enum logic [3:0] {
		MODE_ONE_SHOT = 4'h1,
		MODE_CONTINUOUS = 4'h2,
		MODE_MONITOR = 4'h8,
		MODE_ONE_SHOT_MON = 4'h9
	} lpa_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_TRACK = 2'b10,
		ST_WATCH = 2'b11
	} lpa_state_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lpa_reg_req_t;
endpackage

// File: lpa_align.sv
// LMFC to SYSREF phase alignment control, status and register file.
`timescale 1ns/10ps
module lpa_align
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire lpa_pkg::lpa_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic [2:0] link_subclass,
	input wire logic [3:0] interp_factor,
	input wire logic sysref_in,
	input wire logic [3:0] sysref_phase_err,
	output logic lmfc_adjust,
	output logic [3:0] lmfc_adjust_err,
	output logic [3:0] present_phase_error
);
	lpa_pkg::lpa_state_t state_ff, nxt_state;
	logic [1:0] window_ff, nxt_window;
	logic [7:0] control_ff, nxt_control;
	logic [3:0] prev_err_ff, nxt_prev_err;
	logic prev_low_ff, nxt_prev_low, prev_high_ff, nxt_prev_high;
	logic tripped_ff, nxt_tripped, rotated_ff, nxt_rotated;
	logic locked_ff, nxt_locked, limit_ff, nxt_limit;
	logic bad_subclass_ff, nxt_bad_subclass;
	logic bad_interp_factor_flag_ff, nxt_bad_interp;
	logic adjust_ff, nxt_adjust, align_logic_on;
	logic [3:0] adjust_err_ff, nxt_adjust_err;
	logic [3:0] present_err_ff, nxt_present_err;
	logic [7:0] rdata_ff, nxt_rdata;
	logic ctl_wr, arm_wr, clr_sticky, clr_prev;
	logic err_low, err_high, outside, adjust_now, trip_now;
	logic signed [4:0] err_s, win_s;
	lpa_pkg::lpa_mode_t align_mode_select;
	default clocking lpa_core_cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	assign align_logic_on = control_ff[lpa_pkg::CTL_ON_BIT];
	assign align_mode_select = lpa_pkg::lpa_mode_t'(control_ff[3:0]);
	assign ctl_wr = reg_req.wr && (reg_req.addr == lpa_pkg::ADDR_CONTROL);
	// Arming takes effect on a write of one to the arming bit.
	assign arm_wr = ctl_wr && reg_req.wdata[lpa_pkg::CTL_ARM_BIT];
	// Clears act only on a zero to one change of the control bit.
	assign clr_sticky = ctl_wr && reg_req.wdata[lpa_pkg::CTL_CLR_STICKY_BIT]
		&& !control_ff[lpa_pkg::CTL_CLR_STICKY_BIT];
	assign clr_prev = ctl_wr && reg_req.wdata[lpa_pkg::CTL_CLR_PREV_BIT]
		&& !control_ff[lpa_pkg::CTL_CLR_PREV_BIT];
	// Window compare on the signed error against plus or minus window.
	assign err_s = {sysref_phase_err[3], sysref_phase_err};
	assign win_s = {3'h0, window_ff};
	assign err_low = err_s < -win_s;
	assign err_high = err_s > win_s;
	assign outside = err_low || err_high;
	// Only armed or continuous states move the clocks, and only outside.
	assign adjust_now = sysref_in && outside
		&& (state_ff == lpa_pkg::ST_ARMED || state_ff == lpa_pkg::ST_TRACK);
	assign trip_now = sysref_in && (state_ff == lpa_pkg::ST_ARMED);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_window = window_ff;
		nxt_control = control_ff;
		nxt_prev_err = prev_err_ff;
		nxt_prev_low = prev_low_ff;
		nxt_prev_high = prev_high_ff;
		nxt_tripped = tripped_ff;
		nxt_rotated = rotated_ff;
		nxt_locked = locked_ff;
		nxt_limit = limit_ff;
		nxt_adjust = adjust_now;
		nxt_adjust_err = adjust_now ? sysref_phase_err : adjust_err_ff;
		nxt_present_err = present_err_ff;
		// Configuration checks follow the live inputs.
		nxt_bad_subclass = link_subclass > lpa_pkg::MAX_SUBCLASS;
		nxt_bad_interp = !(interp_factor == lpa_pkg::INTERP_X1
			|| interp_factor == lpa_pkg::INTERP_X2
			|| interp_factor == lpa_pkg::INTERP_X4
			|| interp_factor == lpa_pkg::INTERP_X8);
		// Only the two window bits are writable.
		if (reg_req.wr && reg_req.addr == lpa_pkg::ADDR_ERR_WINDOW)
			nxt_window = reg_req.wdata[1:0];
		if (ctl_wr)
			nxt_control = reg_req.wdata;
		// Clears first so that a coincident event wins.
		if (clr_sticky)
		begin
			nxt_tripped = 1'b0;
			nxt_rotated = 1'b0;
		end
		if (clr_prev)
		begin
			nxt_prev_err = 4'h0;
			nxt_prev_low = 1'b0;
			nxt_prev_high = 1'b0;
		end
		if (sysref_in && state_ff != lpa_pkg::ST_IDLE)
		begin
			nxt_locked = !outside;
			nxt_limit = outside;
			nxt_present_err = sysref_phase_err;
		end
		// SYSREF while armed sets the sticky tripped flag.
		if (trip_now)
			nxt_tripped = 1'b1;
		if (adjust_now)
		begin
			// Record the error and its side, zero the live error.
			nxt_prev_err = sysref_phase_err;
			nxt_prev_low = err_low;
			nxt_prev_high = err_high;
			nxt_present_err = 4'h0;
			nxt_rotated = 1'b1;
		end
		// Mode selection drives the state machine.
		case (state_ff)
			lpa_pkg::ST_IDLE:
			begin
				case (align_mode_select)
					lpa_pkg::MODE_CONTINUOUS: nxt_state = lpa_pkg::ST_TRACK;
					lpa_pkg::MODE_MONITOR: nxt_state = lpa_pkg::ST_WATCH;
					lpa_pkg::MODE_ONE_SHOT,
					lpa_pkg::MODE_ONE_SHOT_MON:
						if (arm_wr)
							nxt_state = lpa_pkg::ST_ARMED;
					default: nxt_state = lpa_pkg::ST_IDLE;
				endcase
			end
			lpa_pkg::ST_ARMED:
			begin
				if (sysref_in)
				begin
					if (align_mode_select == lpa_pkg::MODE_ONE_SHOT_MON)
						nxt_state = lpa_pkg::ST_WATCH;
					else
						nxt_state = lpa_pkg::ST_IDLE;
				end
			end
			lpa_pkg::ST_TRACK:
			begin
				if (align_mode_select != lpa_pkg::MODE_CONTINUOUS)
					nxt_state = lpa_pkg::ST_IDLE;
			end
			lpa_pkg::ST_WATCH:
			begin
				if (align_mode_select != lpa_pkg::MODE_MONITOR
					&& align_mode_select != lpa_pkg::MODE_ONE_SHOT_MON)
					nxt_state = lpa_pkg::ST_IDLE;
				else if (arm_wr
					&& align_mode_select == lpa_pkg::MODE_ONE_SHOT_MON)
					nxt_state = lpa_pkg::ST_ARMED;
			end
			default: nxt_state = lpa_pkg::ST_IDLE;
		endcase
		// With the logic switched off the machine rests.
		if (!align_logic_on)
			nxt_state = lpa_pkg::ST_IDLE;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state_ff <= lpa_pkg::ST_IDLE;
			window_ff <= 2'h0;
			control_ff <= lpa_pkg::RESET_BYTE;
			prev_err_ff <= 4'h0;
			prev_low_ff <= 1'b0;
			prev_high_ff <= 1'b0;
			tripped_ff <= 1'b0;
			rotated_ff <= 1'b0;
			locked_ff <= 1'b0;
			limit_ff <= 1'b0;
			bad_subclass_ff <= 1'b0;
			bad_interp_factor_flag_ff <= 1'b0;
			adjust_ff <= 1'b0;
			adjust_err_ff <= 4'h0;
			present_err_ff <= 4'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			window_ff <= nxt_window;
			control_ff <= nxt_control;
			prev_err_ff <= nxt_prev_err;
			prev_low_ff <= nxt_prev_low;
			prev_high_ff <= nxt_prev_high;
			tripped_ff <= nxt_tripped;
			rotated_ff <= nxt_rotated;
			locked_ff <= nxt_locked;
			limit_ff <= nxt_limit;
			bad_subclass_ff <= nxt_bad_subclass;
			bad_interp_factor_flag_ff <= nxt_bad_interp;
			adjust_ff <= nxt_adjust;
			adjust_err_ff <= nxt_adjust_err;
			present_err_ff <= nxt_present_err;
		end
	end

	// Read data is registered one cycle after the read request.
	always_comb
	begin
		nxt_rdata = lpa_pkg::RESET_BYTE;
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				lpa_pkg::ADDR_CHECKS:
				begin
					nxt_rdata[lpa_pkg::CHK_SUBCLASS_BIT] = bad_subclass_ff;
					nxt_rdata[lpa_pkg::CHK_INTERP_BIT] =
						bad_interp_factor_flag_ff;
				end
				lpa_pkg::ADDR_ERR_WINDOW: nxt_rdata[1:0] = window_ff;
				lpa_pkg::ADDR_PREV_ERR_LOW: nxt_rdata[3:0] = prev_err_ff;
				lpa_pkg::ADDR_PREV_ERR_HIGH:
				begin
					nxt_rdata[lpa_pkg::PREV_LOW_BIT] = prev_low_ff;
					nxt_rdata[lpa_pkg::PREV_HIGH_BIT] = prev_high_ff;
				end
				lpa_pkg::ADDR_CONTROL: nxt_rdata = control_ff;
				lpa_pkg::ADDR_STATUS:
				begin
					// Busy while waiting armed or tracking.
					nxt_rdata[lpa_pkg::STAT_BUSY_BIT] =
						(state_ff == lpa_pkg::ST_ARMED)
						|| (state_ff == lpa_pkg::ST_TRACK);
					nxt_rdata[lpa_pkg::STAT_LOCK_BIT] = locked_ff;
					nxt_rdata[lpa_pkg::STAT_ROTATE_BIT] = rotated_ff;
					nxt_rdata[lpa_pkg::STAT_LIMIT_BIT] = limit_ff;
					nxt_rdata[lpa_pkg::STAT_TRIP_BIT] = tripped_ff;
				end
				default: nxt_rdata = lpa_pkg::RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			rdata_ff <= lpa_pkg::RESET_BYTE;
		else
			rdata_ff <= nxt_rdata;
	end

	assign reg_rdata = rdata_ff;
	assign lmfc_adjust = adjust_ff;
	assign lmfc_adjust_err = adjust_err_ff;
	assign present_phase_error = present_err_ff;

	property p_subclass;
		1'b1 |=> bad_subclass_ff == ($past(link_subclass) > 3'h1);
	endproperty
	a_subclass: assert property (p_subclass)
		else $error("Subclass flag wrong.");
	property p_interp;
		(interp_factor == 4'h3) |=> bad_interp_factor_flag_ff;
	endproperty
	a_interp: assert property (p_interp)
		else $error("Interpolation flag missed.");
	property p_inside;
		(sysref_in && !outside) |=> !lmfc_adjust;
	endproperty
	a_inside: assert property (p_inside)
		else $error("Adjusted inside window.");
	property p_outside;
		(sysref_in && outside && state_ff == lpa_pkg::ST_TRACK)
		|=> lmfc_adjust && lmfc_adjust_err == $past(sysref_phase_err);
	endproperty
	a_outside: assert property (p_outside)
		else $error("No adjustment outside window.");
	property p_record;
		lmfc_adjust |-> prev_err_ff == lmfc_adjust_err
			&& present_phase_error == 4'h0;
	endproperty
	a_record: assert property (p_record)
		else $error("Previous error not recorded.");
	property p_low;
		adjust_now && err_low |=> prev_low_ff && !prev_high_ff;
	endproperty
	a_low: assert property (p_low)
		else $error("Low flag wrong.");
	property p_high;
		adjust_now && err_high |=> prev_high_ff && !prev_low_ff;
	endproperty
	a_high: assert property (p_high)
		else $error("High flag wrong.");
	property p_off;
		!align_logic_on ##1 !align_logic_on |-> state_ff == lpa_pkg::ST_IDLE;
	endproperty
	a_off: assert property (p_off)
		else $error("Machine active while off.");
	property p_arm;
		arm_wr && state_ff == lpa_pkg::ST_IDLE && align_logic_on
		&& align_mode_select == lpa_pkg::MODE_ONE_SHOT
		&& reg_req.wdata[lpa_pkg::CTL_ON_BIT]
		|=> state_ff == lpa_pkg::ST_ARMED;
	endproperty
	a_arm: assert property (p_arm)
		else $error("Arming ignored.");
	property p_clr_sticky;
		clr_sticky && !trip_now && !adjust_now |=> !tripped_ff && !rotated_ff;
	endproperty
	a_clr_sticky: assert property (p_clr_sticky)
		else $error("Sticky flags not cleared.");
	property p_clr_prev;
		clr_prev && !adjust_now |=> prev_err_ff == 4'h0
			&& !prev_low_ff && !prev_high_ff;
	endproperty
	a_clr_prev: assert property (p_clr_prev)
		else $error("Previous error not cleared.");
	property p_trip;
		trip_now |=> tripped_ff && state_ff != lpa_pkg::ST_ARMED;
	endproperty
	a_trip: assert property (p_trip)
		else $error("Trip not recorded.");
	c_oneshot: cover property (state_ff == lpa_pkg::ST_ARMED ##1 lmfc_adjust);
	c_track: cover property (state_ff == lpa_pkg::ST_TRACK && adjust_now);
	c_watch: cover property (state_ff == lpa_pkg::ST_WATCH
		&& sysref_in && outside);
endmodule

// File: lpa_sysref_src.sv
// SYSREF source model that pulses with a chosen phase error.
`timescale 1ns/10ps
module lpa_sysref_src
(
	input wire logic core_clk,
	output logic sysref_in,
	output logic [3:0] sysref_phase_err
);
	initial
	begin
		sysref_in = 1'b0;
		sysref_phase_err = 4'h5;
	end
	// One strobe; the error is scrambled once the strobe has gone.
	task automatic pulse(input logic [3:0] err);
		@(posedge core_clk);
		sysref_in <= 1'b1;
		sysref_phase_err <= err;
		@(posedge core_clk);
		sysref_in <= 1'b0;
		sysref_phase_err <= ~err;
	endtask
endmodule

// File: lpa_align_test.sv
// Self-checking testbench of the phase alignment block.
`timescale 1ns/10ps
`define CHK(g, e) \
begin \
	cmp_count++; \
	if ((g) !== (e)) \
	begin \
		err_count++; \
		$display("[ERR] %0t ns: got %h exp %h", $time, (g), (e)); \
	end \
end
module lpa_align_test;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	lpa_pkg::lpa_reg_req_t reg_req = '0;
	logic [7:0] reg_rdata;
	logic [2:0] link_subclass = 3'h1;
	logic [3:0] interp_factor = 4'h1;
	logic sysref_in;
	logic [3:0] sysref_phase_err;
	logic lmfc_adjust;
	logic [3:0] lmfc_adjust_err;
	logic [3:0] present_phase_error;
	int err_count = 0;
	int cmp_count = 0;
	always #12.5 core_clk = ~core_clk;
	lpa_align uut (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .link_subclass(link_subclass),
		.interp_factor(interp_factor), .sysref_in(sysref_in),
		.sysref_phase_err(sysref_phase_err), .lmfc_adjust(lmfc_adjust),
		.lmfc_adjust_err(lmfc_adjust_err),
		.present_phase_error(present_phase_error));
	lpa_sysref_src src (.core_clk(core_clk), .sysref_in(sysref_in),
		.sysref_phase_err(sysref_phase_err));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		reg_req <= '{a, d, 1'b0, 1'b0};
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge core_clk);
		reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		reg_req <= '{a, 8'h00, 1'b0, 1'b0};
		#1;
		`CHK(reg_rdata & m, e)
	endtask
	// Sends one SYSREF and checks whether the clocks were adjusted.
	task automatic sref(input logic [3:0] err, input logic adj,
		input logic pres);
		src.pulse(err);
		#1;
		`CHK(lmfc_adjust, adj)
		if (adj)
		begin
			`CHK(lmfc_adjust_err, err)
			`CHK(present_phase_error, 4'h0)
		end
		else if (pres)
			`CHK(present_phase_error, err)
	endtask
	task automatic t_regs;
		rchk(lpa_pkg::ADDR_CHECKS, 8'hFF, 8'h00);
		rchk(lpa_pkg::ADDR_ERR_WINDOW, 8'hFF, 8'h00);
		rchk(lpa_pkg::ADDR_PREV_ERR_HIGH, 8'hFF, 8'h00);
		rchk(lpa_pkg::ADDR_CONTROL, 8'hFF, 8'h00);
		rchk(lpa_pkg::ADDR_STATUS, 8'hFF, 8'h00);
		rchk(8'h3F, 8'hFF, 8'h00);
		wr(lpa_pkg::ADDR_PREV_ERR_LOW, 8'hFF);
		rchk(lpa_pkg::ADDR_PREV_ERR_LOW, 8'hFF, 8'h00);
		wr(lpa_pkg::ADDR_ERR_WINDOW, 8'hFF);
		rchk(lpa_pkg::ADDR_ERR_WINDOW, 8'hFF, 8'h03);
		wr(lpa_pkg::ADDR_ERR_WINDOW, 8'h01);
		$display("test regs done");
	endtask
	task automatic t_checks;
		logic [7:0] e;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge core_clk);
			link_subclass <= 3'(i);
			interp_factor <= 4'(i);
			e = {6'h00, 3'(i) > 3'h1, !(i == 1 || i == 2 || i == 4 || i == 8)};
			rchk(lpa_pkg::ADDR_CHECKS, 8'hFF, e);
		end
		@(posedge core_clk);
		link_subclass <= 3'h1;
		interp_factor <= 4'h1;
		$display("test checks done");
	endtask
	task automatic t_oneshot;
		wr(lpa_pkg::ADDR_CONTROL, 8'h81);
		rchk(lpa_pkg::ADDR_STATUS, 8'h80, 8'h00);
		wr(lpa_pkg::ADDR_CONTROL, 8'hC1);
		rchk(lpa_pkg::ADDR_STATUS, 8'h80, 8'h80);
		sref(4'hC, 1'b1, 1'b1);
		rchk(lpa_pkg::ADDR_PREV_ERR_LOW, 8'hFF, 8'h0C);
		rchk(lpa_pkg::ADDR_PREV_ERR_HIGH, 8'hFF, 8'h80);
		rchk(lpa_pkg::ADDR_CONTROL, 8'hFF, 8'hC1);
		rchk(lpa_pkg::ADDR_STATUS, 8'hFF, 8'h07);
		$display("test oneshot done");
	endtask
	task automatic t_cont;
		logic [3:0] errs [4] = '{4'hF, 4'h1, 4'hE, 4'h2};
		logic adjs [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
		wr(lpa_pkg::ADDR_CONTROL, 8'h82);
		rchk(lpa_pkg::ADDR_STATUS, 8'h80, 8'h80);
		for (int i = 0; i < 4; i++)
			sref(errs[i], adjs[i], 1'b1);
		rchk(lpa_pkg::ADDR_PREV_ERR_LOW, 8'hFF, 8'h02);
		rchk(lpa_pkg::ADDR_PREV_ERR_HIGH, 8'hFF, 8'h40);
		wr(lpa_pkg::ADDR_CONTROL, 8'hB2);
		rchk(lpa_pkg::ADDR_PREV_ERR_LOW, 8'hFF, 8'h00);
		rchk(lpa_pkg::ADDR_PREV_ERR_HIGH, 8'hFF, 8'h00);
		rchk(lpa_pkg::ADDR_STATUS, 8'h05, 8'h00);
		$display("test continuous done");
	endtask
	task automatic t_modes;
		wr(lpa_pkg::ADDR_CONTROL, 8'h02);
		sref(4'h7, 1'b0, 1'b0);
		wr(lpa_pkg::ADDR_CONTROL, 8'h88);
		rchk(lpa_pkg::ADDR_STATUS, 8'h80, 8'h00);
		sref(4'h7, 1'b0, 1'b1);
		rchk(lpa_pkg::ADDR_STATUS, 8'h02, 8'h02);
		wr(lpa_pkg::ADDR_CONTROL, 8'h89);
		wr(lpa_pkg::ADDR_CONTROL, 8'hC9);
		sref(4'h4, 1'b1, 1'b1);
		sref(4'h4, 1'b0, 1'b1);
		$display("test modes done");
	endtask
	task end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#(2000 * 25);
		err_count++;
		$display("[ERR] %0t ns: watchdog expired", $time);
		end_of_test();
	end
	initial
	begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		t_regs();
		t_checks();
		t_oneshot();
		t_cont();
		t_modes();
		end_of_test();
	end
endmodule
